// ---- acri_defines.vh ----
// Purpose: constants for the converter clock and result interface
// Assumes: internal I/O register bus of the processor core, 8-bit data
// Notes:   definitions only
`ifndef ACRI_DEFINES_VH
`define ACRI_DEFINES_VH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define ACRI_ADDR_RES_LOW  6'h04
`define ACRI_ADDR_RES_HIGH 6'h05
`define ACRI_ADDR_CTRL     6'h06
`define ACRI_ADDR_CHSEL    6'h07

// ---------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------
`define ACRI_CTRL_EN    7
`define ACRI_CTRL_START 6
`define ACRI_CTRL_FREE  5
`define ACRI_CTRL_FLAG  4
`define ACRI_CTRL_IE    3
`define ACRI_CTRL_PS_HI 2
`define ACRI_CTRL_PS_LO 0

// ---------------------------------------------------------------
// Channel select register fields
// ---------------------------------------------------------------
`define ACRI_CHS_LEFT   5
`define ACRI_CHS_MUX_HI 4
`define ACRI_CHS_MUX_LO 0
`define ACRI_CHS_REF_HI 7
`define ACRI_CHS_REF_LO 6

// ---------------------------------------------------------------
// Conversion timing in converter clock cycles
// ---------------------------------------------------------------
`define ACRI_CONV_NORMAL   5'd13
`define ACRI_CONV_EXTENDED 5'd25
`define ACRI_SAMPLE_NORMAL 5'd1
`define ACRI_SAMPLE_EXT    5'd13

// ---------------------------------------------------------------
// Prescaler terminal counts, one less than the division factor
// ---------------------------------------------------------------
`define ACRI_LAST_DIV2   7'h01
`define ACRI_LAST_DIV4   7'h03
`define ACRI_LAST_DIV8   7'h07
`define ACRI_LAST_DIV16  7'h0f
`define ACRI_LAST_DIV32  7'h1f
`define ACRI_LAST_DIV64  7'h3f
`define ACRI_LAST_DIV128 7'h7f

// ---------------------------------------------------------------
// Result field positions
// ---------------------------------------------------------------
`define ACRI_RES_MSB      9
`define ACRI_RES_HB_LSB   8
`define ACRI_RES_LB_MSB   7
`define ACRI_RES_LEFT_LSB 2
`define ACRI_RES_LL_MSB   1
`define ACRI_RES_LSB      0

`define ACRI_RESET_BYTE 8'h00

`endif

// ---- acri_prescaler.v ----
// Purpose: converter clock prescaler, one tick per converter clock period
// Assumes: runs on the system clock, no gating
// Notes:   tick is a one-cycle pulse, the divided clock a level
`timescale 1ns/100ps
`default_nettype none
`include "acri_defines.vh"

module acri_prescaler (
  input  wire       mclk,
  input  wire       arst_n,
  input  wire       run,
  input  wire [2:0] sel,
  output reg        tick,
  output wire       conv_clk
);

  reg  [6:0] count_reg;
  reg  [6:0] count_next;
  reg  [6:0] last;
  reg        clk_reg;

  // ---------------------------------------------------------------
  // Division factor
  // ---------------------------------------------------------------
  // Codes 0 and 1 both divide by two
  always @* begin
    case (sel)
      3'h0, 3'h1: last = `ACRI_LAST_DIV2;
      3'h2:       last = `ACRI_LAST_DIV4;
      3'h3:       last = `ACRI_LAST_DIV8;
      3'h4:       last = `ACRI_LAST_DIV16;
      3'h5:       last = `ACRI_LAST_DIV32;
      3'h6:       last = `ACRI_LAST_DIV64;
      default:    last = `ACRI_LAST_DIV128;
    endcase
  end

  // Counter held cleared while run is low so an enabling start lands on a fresh edge
  always @* begin
    count_next = count_reg + 7'h01;
    if (!run || count_reg >= last) begin
      count_next = 7'h00;
    end
  end

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      count_reg <= 7'h00;
      tick      <= 1'b0;
      clk_reg   <= 1'b0;
    end else begin
      count_reg <= count_next;
      tick      <= run && (count_reg >= last);
      clk_reg   <= run && (count_next > (last >> 1));
    end
  end

  // Divided clock: high in the upper half of each period; taken from a
  // flop so the counter decode cannot glitch onto the output
  assign conv_clk = clk_reg;

endmodule
`default_nettype wire

// ---- acri_top.v ----
// Purpose: converter control, prescaler, result register and interrupt
// Assumes: core bus sampled on mclk; analog core returns code on analog_code, taken at conversion end
// Notes:   result register reads are the low byte then high byte pair
`timescale 1ns/100ps
`default_nettype none
`include "acri_defines.vh"

module acri_top (
  input  wire       mclk,
  input  wire       arst_n,
  input  wire [5:0] io_addr,
  input  wire       io_wr,
  input  wire       io_rd,
  input  wire [7:0] io_wdata,
  output reg  [7:0] io_rdata,
  input  wire       global_irq_enable,
  input  wire       irq_vector_taken,
  input  wire [9:0] analog_code,
  output wire       conv_clk,
  output reg  [4:0] active_channel,
  output reg  [1:0] active_reference,
  output reg        sample_hold,
  output wire       conv_busy,
  output wire       conv_irq
);

  localparam ST_IDLE = 3'b001;
  localparam ST_EXT  = 3'b010;
  localparam ST_CONV = 3'b100;

  reg  [2:0] state_reg;
  reg  [4:0] step_reg;
  reg  [7:0] ctrl_reg;
  reg  [7:0] chsel_reg;
  reg  [9:0] result_reg;
  reg        lock_reg;
  reg        first_reg;
  wire       tick;
  wire       done_tick;
  wire       res_load;
  wire       left;
  wire       wr_ctrl;
  wire       rd_low;
  wire       rd_high;
  wire [7:0] low_view;
  wire [7:0] high_view;
  wire [4:0] conv_len;
  wire [4:0] sample_at;

  // ---------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------
  // Result-byte reads move the lock, so they need the read strobe;
  // read data itself follows the address alone
  assign wr_ctrl = io_wr && (io_addr == `ACRI_ADDR_CTRL);
  assign rd_low  = io_rd && (io_addr == `ACRI_ADDR_RES_LOW);
  assign rd_high = io_rd && (io_addr == `ACRI_ADDR_RES_HIGH);
  assign left    = chsel_reg[`ACRI_CHS_LEFT];

  // ---------------------------------------------------------------
  // Prescaler
  // ---------------------------------------------------------------
  acri_prescaler u_presc (
    .mclk     (mclk),
    .arst_n   (arst_n),
    .run      (ctrl_reg[`ACRI_CTRL_EN]),
    .sel      (ctrl_reg[`ACRI_CTRL_PS_HI:`ACRI_CTRL_PS_LO]),
    .tick     (tick),
    .conv_clk (conv_clk)
  );

  // ---------------------------------------------------------------
  // Conversion sequencer
  // ---------------------------------------------------------------
  assign conv_len  = (state_reg == ST_EXT) ? `ACRI_CONV_EXTENDED : `ACRI_CONV_NORMAL;
  assign sample_at = (state_reg == ST_EXT) ? `ACRI_SAMPLE_EXT : `ACRI_SAMPLE_NORMAL;
  assign done_tick = tick && (state_reg == ST_CONV) && (step_reg == conv_len - 5'd1);
  assign conv_busy = (state_reg != ST_IDLE);

  // Sequencer; disabling the converter aborts any conversion
  // The first start after enable runs a long settling pass first,
  // which yields no result and raises no flag
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg        <= ST_IDLE;
      step_reg         <= 5'd0;
      first_reg        <= 1'b1;
      sample_hold      <= 1'b0;
      active_channel   <= 5'd0;
      active_reference <= 2'd0;
    end else if (!ctrl_reg[`ACRI_CTRL_EN]) begin
      state_reg   <= ST_IDLE;
      step_reg    <= 5'd0;
      first_reg   <= 1'b1;
      sample_hold <= 1'b0;
    end else begin
      sample_hold <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (ctrl_reg[`ACRI_CTRL_START] && tick) begin
            // Channel latched only at a start, never mid conversion
            active_channel   <= chsel_reg[`ACRI_CHS_MUX_HI:`ACRI_CHS_MUX_LO];
            active_reference <= chsel_reg[`ACRI_CHS_REF_HI:`ACRI_CHS_REF_LO];
            step_reg         <= 5'd0;
            first_reg        <= 1'b0;
            state_reg        <= first_reg ? ST_EXT : ST_CONV;
          end
        end
        ST_EXT, ST_CONV: begin
          if (tick) begin
            step_reg <= step_reg + 5'd1;
            if (step_reg == sample_at) begin
              sample_hold <= 1'b1;
            end
            if (step_reg == conv_len - 5'd1) begin
              step_reg <= 5'd0;
              if (state_reg == ST_EXT) begin
                state_reg <= ST_CONV;
              end else if (ctrl_reg[`ACRI_CTRL_FREE]) begin
                // Next conversion starts on the completing tick, old channel
                // writes after this instant wait one more conversion
                active_channel   <= chsel_reg[`ACRI_CHS_MUX_HI:`ACRI_CHS_MUX_LO];
                active_reference <= chsel_reg[`ACRI_CHS_REF_HI:`ACRI_CHS_REF_LO];
              end else begin
                state_reg <= ST_IDLE;
              end
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Control and channel select registers
  // ---------------------------------------------------------------
  // Hardware set of the done flag beats a same-cycle clear
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg  <= 8'h00;
      chsel_reg <= 8'h00;
    end else begin
      if (io_wr && (io_addr == `ACRI_ADDR_CHSEL)) begin
        chsel_reg <= io_wdata;
      end
      if (wr_ctrl) begin
        ctrl_reg[`ACRI_CTRL_EN]   <= io_wdata[`ACRI_CTRL_EN];
        ctrl_reg[`ACRI_CTRL_FREE] <= io_wdata[`ACRI_CTRL_FREE];
        ctrl_reg[`ACRI_CTRL_IE]   <= io_wdata[`ACRI_CTRL_IE];
        ctrl_reg[`ACRI_CTRL_PS_HI:`ACRI_CTRL_PS_LO] <=
          io_wdata[`ACRI_CTRL_PS_HI:`ACRI_CTRL_PS_LO];
      end
      // Start bit: writing zero has no effect, clears at single-mode end
      if (wr_ctrl && io_wdata[`ACRI_CTRL_START]) begin
        ctrl_reg[`ACRI_CTRL_START] <= 1'b1;
      end else if (!ctrl_reg[`ACRI_CTRL_EN] ||
                   (done_tick && !ctrl_reg[`ACRI_CTRL_FREE])) begin
        ctrl_reg[`ACRI_CTRL_START] <= 1'b0;
      end
      if (res_load) begin
        ctrl_reg[`ACRI_CTRL_FLAG] <= 1'b1;
      end else if (irq_vector_taken ||
                   (wr_ctrl && io_wdata[`ACRI_CTRL_FLAG])) begin
        ctrl_reg[`ACRI_CTRL_FLAG] <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Result register and read lock
  // ---------------------------------------------------------------
  // A completion during lock is dropped so low and high stay a pair;
  // a low-byte read on the completing edge locks at once, else the
  // low byte handed out would be older than the high byte after it.
  // Limitation: software that never reads the high byte stalls updates
  assign res_load = done_tick && !lock_reg && !rd_low;

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      result_reg <= 10'h000;
      lock_reg   <= 1'b0;
    end else begin
      if (res_load) begin
        result_reg <= analog_code;
      end
      if (rd_high) begin
        lock_reg <= 1'b0;
      end else if (rd_low) begin
        lock_reg <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Result presentation
  // ---------------------------------------------------------------
  // Alignment is applied at read time so it follows the bit at once
  assign high_view = left ? result_reg[`ACRI_RES_MSB:`ACRI_RES_LEFT_LSB]
                          : {6'h00, result_reg[`ACRI_RES_MSB:`ACRI_RES_HB_LSB]};
  assign low_view  = left ? {result_reg[`ACRI_RES_LL_MSB:`ACRI_RES_LSB], 6'h00}
                          : result_reg[`ACRI_RES_LB_MSB:`ACRI_RES_LSB];

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      io_rdata <= `ACRI_RESET_BYTE;
    end else begin
      case (io_addr)
        `ACRI_ADDR_RES_LOW:  io_rdata <= low_view;
        `ACRI_ADDR_RES_HIGH: io_rdata <= high_view;
        `ACRI_ADDR_CTRL:     io_rdata <= ctrl_reg;
        `ACRI_ADDR_CHSEL:    io_rdata <= chsel_reg;
        default:             io_rdata <= `ACRI_RESET_BYTE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Interrupt request
  // ---------------------------------------------------------------
  // Interrupt follows the flag, which rises with the readable result
  assign conv_irq = ctrl_reg[`ACRI_CTRL_FLAG] && ctrl_reg[`ACRI_CTRL_IE]
                    && global_irq_enable;

endmodule
`default_nettype wire

// ---- acri_checker.sv ----
// Purpose: port-level assertions for the converter result interface
// Assumes: one mclk domain, asynchronous active-low reset
// Notes:   left-align bit shadowed from channel-select writes
`timescale 1ns/100ps
`default_nettype none
`include "acri_defines.vh"
module acri_checker (
  input wire logic       mclk,
  input wire logic       arst_n,
  input wire logic [5:0] io_addr,
  input wire logic       io_wr,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic       global_irq_enable,
  input wire logic       irq_vector_taken,
  input wire logic       sample_hold,
  input wire logic       conv_busy,
  input wire logic       conv_irq
);
  logic left_reg;
  logic ie_reg;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  // Shadow of the alignment bit, not visible at the ports otherwise
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n)
      left_reg <= 1'b0;
    else if (io_wr && io_addr == `ACRI_ADDR_CHSEL)
      left_reg <= io_wdata[`ACRI_CHS_LEFT];
  end

  // Shadow of the done-interrupt enable, so a late enable is not a rise
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n)
      ie_reg <= 1'b0;
    else if (io_wr && io_addr == `ACRI_ADDR_CTRL)
      ie_reg <= io_wdata[`ACRI_CTRL_IE];
  end

  // Result reads in each alignment
  sequence s_low_left; io_addr == `ACRI_ADDR_RES_LOW && left_reg; endsequence
  sequence s_high_right; io_addr == `ACRI_ADDR_RES_HIGH && !left_reg; endsequence

  // Idle-only clears, so a completion cannot win the race
  property p_irq_gate; !global_irq_enable |-> !conv_irq; endproperty
  property p_irq_vec; irq_vector_taken && !conv_busy |=> !conv_irq; endproperty
  property p_irq_wclr;
    io_wr && io_addr == `ACRI_ADDR_CTRL && io_wdata[`ACRI_CTRL_FLAG] && !conv_busy |=> !conv_irq;
  endproperty
  property p_irq_end;
    $rose(conv_irq) && $past(global_irq_enable) && $past(ie_reg) |-> $past(conv_busy);
  endproperty
  property p_low_pad; s_low_left |=> io_rdata[5:0] == 6'h00; endproperty
  property p_high_pad; s_high_right |=> io_rdata[7:2] == 6'h00; endproperty
  property p_unmapped; io_addr > 6'h07 || io_addr < 6'h04 |=> io_rdata == 8'h00; endproperty
  property p_sample; sample_hold |-> conv_busy; endproperty

  a_irq_gate: assert property (p_irq_gate) else $error("irq without global enable");
  a_irq_vec: assert property (p_irq_vec) else $error("irq kept after vector");
  a_irq_wclr: assert property (p_irq_wclr) else $error("irq kept after flag write");
  a_irq_end: assert property (p_irq_end) else $error("irq rose with no conversion");
  a_low_pad: assert property (p_low_pad) else $error("left low byte padding set");
  a_high_pad: assert property (p_high_pad) else $error("right high byte padding set");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_sample: assert property (p_sample) else $error("sample outside conversion");
endmodule
`default_nettype wire

// ---- acri_analog_model.sv ----
// Purpose: analog core stand-in returning a code per channel
// Assumes: code read by the design on its completion edge
// Notes:   ground and reference channels give the end codes
`timescale 1ns/100ps
`default_nettype none
module acri_analog_model (
  input  wire logic [4:0] active_channel,
  output logic      [9:0] analog_code
);
  // Distinct pattern per channel so a stale channel shows in the result;
  // only the code is driven, no shared digital pin toggles
  always_comb begin
    if (active_channel == 5'h1f)
      analog_code = 10'h000;
    else if (active_channel == 5'h1e)
      analog_code = 10'h3ff;
    else
      analog_code = {active_channel, ~active_channel};
  end
endmodule
`default_nettype wire

// ---- acri_top_tb_top.sv ----
// Purpose: self-checking bench for the converter result interface
// Assumes: acri_top driven through its I/O register port
// Notes:   time-out counts as a mismatch
`timescale 1ns/100ps
`default_nettype none
module acri_top_tb_top;
  logic       mclk = 1'b0;
  logic       arst_n = 1'b0;
  logic       io_wr = 1'b0;
  logic       io_rd = 1'b0;
  logic       gie = 1'b0;
  logic       vec = 1'b0;
  logic [5:0] io_addr = 6'h00;
  logic [7:0] io_wdata = 8'h00;
  logic [7:0] io_rdata;
  logic [9:0] analog_code;
  logic [4:0] active_channel;
  logic [1:0] active_reference;
  logic       sample_hold, conv_busy, conv_irq, conv_clk;
  int         n_fail = 0;
  int         tests_run = 0;
  int         cyc = 0;
  int         i;
  time        t0;
  logic [7:0] div_tab [8] = '{8'h02, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80};

  acri_top i_dut (.mclk(mclk), .arst_n(arst_n), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .global_irq_enable(gie),
    .irq_vector_taken(vec), .analog_code(analog_code), .conv_clk(conv_clk),
    .active_channel(active_channel), .active_reference(active_reference),
    .sample_hold(sample_hold), .conv_busy(conv_busy), .conv_irq(conv_irq));
  acri_analog_model i_model (.active_channel(active_channel), .analog_code(analog_code));

  // Clock and cycle ceiling, well above the expected run
  always #4 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 50000) begin
      n_fail++;
      results();
    end
  end

  task automatic step();
    @(posedge mclk);
    #1;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Idle edge after each access, so back-to-back calls never retoggle a strobe
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    step();
    io_wr = 1'b0;
    step();
  endtask
  // Read strobe held one edge; data lands on that edge
  task automatic rc(input logic [5:0] a, input logic [7:0] exp);
    io_addr = a;
    io_rd = 1'b1;
    step();
    io_rd = 1'b0;
    check(io_rdata, exp);
    step();
  endtask
  // Start, then wait for the interrupt or the end of a single run
  task automatic conv(input logic [7:0] ctl, input logic exp);
    int k;
    bit seen;
    k = 0;
    seen = 1'b0;
    wr(6'h06, ctl);
    while (!(conv_irq === 1'b1 || (seen && conv_busy === 1'b0)) && k < 9000) begin
      seen = seen || conv_busy === 1'b1;
      step();
      k++;
    end
    check({7'h00, conv_irq}, {7'h00, exp});
  endtask
  task automatic results();
    $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (16) @(posedge mclk);
    #1;
    arst_n = 1'b1;
    rc(6'h04, 8'h00);
    rc(6'h05, 8'h00);
    rc(6'h3f, 8'h00);
    $display("test reset values done");
    for (i = 0; i < 8; i++) begin
      wr(6'h06, 8'hc0 | 8'(i));
      @(posedge conv_clk);
      t0 = $time;
      @(posedge conv_clk);
      t0 = $time - t0;
      #1;
      check(8'(t0 / 8), div_tab[i]);
      wr(6'h06, 8'h10);
    end
    $display("test divider done");
    gie = 1'b1;
    wr(6'h07, 8'h04);
    conv(8'hd8, 1'b1);
    rc(6'h06, 8'h98);
    rc(6'h04, 8'h9b);
    rc(6'h05, 8'h00);
    wr(6'h07, 8'h24);
    rc(6'h04, 8'hc0);
    rc(6'h05, 8'h26);
    rc(6'h05, 8'h26);
    $display("test alignment done");
    vec = 1'b1;
    step();
    vec = 1'b0;
    check({7'h00, conv_irq}, 8'h00);
    gie = 1'b0;
    wr(6'h07, 8'h3f);
    conv(8'hd8, 1'b0);
    gie = 1'b1;
    step();
    check({7'h00, conv_irq}, 8'h01);
    wr(6'h06, 8'h98);
    check({7'h00, conv_irq}, 8'h00);
    rc(6'h04, 8'h00);
    rc(6'h05, 8'h00);
    $display("test interrupt done");
    wr(6'h07, 8'h1e);
    conv(8'he8, 1'b1);
    rc(6'h04, 8'hff);
    wr(6'h07, 8'hc4);
    check({3'h0, active_channel}, 8'h1e);
    check({6'h00, active_reference}, 8'h00);
    repeat (200) step();
    rc(6'h05, 8'h03);
    repeat (100) step();
    check({6'h00, active_reference}, 8'h03);
    rc(6'h04, 8'h9b);
    rc(6'h05, 8'h00);
    wr(6'h06, 8'h10);
    $display("test free run done");
    results();
  end
endmodule

bind acri_top acri_checker i_chk (.mclk(mclk), .arst_n(arst_n), .io_addr(io_addr),
  .io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(io_rdata),
  .global_irq_enable(global_irq_enable), .irq_vector_taken(irq_vector_taken),
  .sample_hold(sample_hold), .conv_busy(conv_busy), .conv_irq(conv_irq));
`default_nettype wire
